// ---- verilog/rscl_strap_latch.sv ----
`include "rscl_cfg.svh"

module rscl_strap_latch #(
    parameter int NUM_PINS = `RSCL_NUM_PINS
) (
    // Clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       reset_i,
    // APB slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire logic [`RSCL_ADDR_W-1:0]    paddr_i,
    input  wire logic [31:0]                pwdata_i,
    output logic [31:0]                     prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // Strap pads
    input  wire logic [NUM_PINS-1:0]        pad_in_i,
    output logic [NUM_PINS-1:0]             pad_out_o,
    output logic [NUM_PINS-1:0]             pad_oe_o,
    // Normal pin functions
    input  wire logic [3:0]                 front_end_ctrl_i,
    input  wire logic [3:0]                 front_end_ctrl_oe_i,
    input  wire logic                       coex_grant_out_i,
    output logic                            coex_request_in_o,
    output logic                            coex_priority_in_o,
    output logic                            coex_frequency_in_o,
    // Boot configuration
    output rscl_pkg::rscl_strap_s           straps_o,
    output rscl_pkg::rscl_boot_e            boot_mode_o,
    output rscl_pkg::rscl_dbg_e             debug_protocol_strap_o,
    output logic                            ref_osc_40m_o,
    output logic                            dbg_swd_en_o,
    output logic                            dbg_jtag_en_o
);
    import rscl_pkg::*;

    // Fixed per pad, so input-only pads carry no enable logic
    localparam logic [NUM_PINS-1:0] FUNC_OUT_MASK = NUM_PINS'(`RSCL_FUNC_OUT_MASK);

    logic [NUM_PINS-1:0] func_out;
    logic [NUM_PINS-1:0] func_oe;
    logic [NUM_PINS-1:0] func_in;
    logic [NUM_PINS-1:0] strap_raw;
    logic                ctrl_out_en;
    rscl_boot_e          next_boot_mode;
    logic                apb_setup;
    logic                apb_access;
    logic                addr_hit;

    always_comb begin
        func_out = '0;
        func_oe  = '0;
        func_out[3:0]                  = front_end_ctrl_i;
        func_oe[3:0]                   = front_end_ctrl_oe_i & {4{ctrl_out_en}};
        func_out[`RSCL_PIN_COEX_GNT]   = coex_grant_out_i;
        func_oe[`RSCL_PIN_COEX_GNT]    = ctrl_out_en;
    end

    // One cell per strap pad
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_cell
            rscl_strap_cell #(
                .FUNC_OUT (FUNC_OUT_MASK[gi])
            ) u_cell (
                .clk_sys_i  (clk_sys_i),
                .reset_i    (reset_i),
                .pad_in_i   (pad_in_i[gi]),
                .pad_out_o  (pad_out_o[gi]),
                .pad_oe_o   (pad_oe_o[gi]),
                .func_out_i (func_out[gi]),
                .func_oe_i  (func_oe[gi]),
                .func_in_o  (func_in[gi]),
                .strap_o    (strap_raw[gi])
            );
        end
    endgenerate

    assign coex_request_in_o   = func_in[`RSCL_PIN_COEX_REQ];
    assign coex_priority_in_o  = func_in[`RSCL_PIN_COEX_PRI];
    assign coex_frequency_in_o = func_in[`RSCL_PIN_COEX_FREQ];

    // Host code bit order follows the pad order
    always_comb begin
        straps_o.rsv0      = strap_raw[`RSCL_PIN_FE0];
        straps_o.rsv1      = strap_raw[`RSCL_PIN_FE1];
        straps_o.dbg_sel   = strap_raw[`RSCL_PIN_FE2];
        straps_o.osc_sel   = strap_raw[`RSCL_PIN_FE3];
        straps_o.host_code = {strap_raw[`RSCL_PIN_COEX_FREQ], strap_raw[`RSCL_PIN_COEX_PRI],
                              strap_raw[`RSCL_PIN_COEX_GNT], strap_raw[`RSCL_PIN_COEX_REQ]};
    end

    always_comb begin
        unique case (straps_o.host_code)
            `RSCL_HOST_FLASH:    next_boot_mode = RSCL_BOOT_FLASH;
            `RSCL_HOST_PROG:     next_boot_mode = RSCL_BOOT_PROG;
            `RSCL_HOST_SERIAL:   next_boot_mode = RSCL_BOOT_SERIAL;
            `RSCL_HOST_PROG_SDIO: next_boot_mode = RSCL_BOOT_PROG_SDIO;
            `RSCL_HOST_SER_SDIO: next_boot_mode = RSCL_BOOT_SERIAL_SDIO;
            `RSCL_HOST_RESERVED: next_boot_mode = RSCL_BOOT_RESERVED;
            default:             next_boot_mode = RSCL_BOOT_UNDEFINED;
        endcase
    end

    // Decoded outputs follow the straps one clock later
    always_ff @(posedge clk_sys_i) begin
        boot_mode_o <= next_boot_mode;
    end

    always_ff @(posedge clk_sys_i) begin
        debug_protocol_strap_o <= rscl_dbg_e'(straps_o.dbg_sel);
        dbg_jtag_en_o          <= (straps_o.dbg_sel == `RSCL_DBG_JTAG);
        dbg_swd_en_o           <= (straps_o.dbg_sel == `RSCL_DBG_SWD);
    end

    always_ff @(posedge clk_sys_i) begin
        ref_osc_40m_o <= (straps_o.osc_sel == `RSCL_OSC_40M);
    end

    // APB slave, zero wait: read data registered in the setup cycle
    assign apb_setup  = psel_i && !penable_i;
    assign apb_access = psel_i && penable_i;
    assign addr_hit   = (paddr_i == `RSCL_OFS_STRAP) || (paddr_i == `RSCL_OFS_BOOT)
                        || (paddr_i == `RSCL_OFS_CTRL);
    assign pready_o   = apb_access;
    assign pslverr_o  = apb_access && !addr_hit;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ctrl_out_en <= `RSCL_CTRL_RST;
        end else if (apb_access && pwrite_i && paddr_i == `RSCL_OFS_CTRL) begin
            ctrl_out_en <= pwdata_i[`RSCL_CTRL_OUTEN_BIT];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prdata_o <= '0;
        end else if (apb_setup && !pwrite_i) begin
            prdata_o <= '0;
            unique case (paddr_i)
                `RSCL_OFS_STRAP: prdata_o[NUM_PINS-1:0] <= straps_o;
                `RSCL_OFS_BOOT: begin
                    prdata_o[`RSCL_BOOT_MODE_LSB +: 3]  <= boot_mode_o;
                    prdata_o[`RSCL_BOOT_JTAG_BIT]       <= dbg_jtag_en_o;
                    prdata_o[`RSCL_BOOT_OSC_BIT]        <= ref_osc_40m_o;
                end
                `RSCL_OFS_CTRL: prdata_o[`RSCL_CTRL_OUTEN_BIT] <= ctrl_out_en;
                default: prdata_o <= '0;
            endcase
        end
    end

    a_pads_input_rst: assert property (@(posedge clk_sys_i)
        reset_i |-> pad_oe_o == '0)
        else $error("Strap pad driven during reset");

    a_func_after_rst: assert property (@(posedge clk_sys_i)
        !reset_i |-> pad_oe_o[`RSCL_PIN_COEX_GNT] == ctrl_out_en
            && pad_out_o[`RSCL_PIN_COEX_GNT] == coex_grant_out_i)
        else $error("Pad not on normal function after reset");

    a_strap_capture: assert property (@(posedge clk_sys_i)
        reset_i |=> strap_raw == $past(pad_in_i))
        else $error("Strap level not captured in reset");

    a_strap_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !$past(reset_i) |-> $stable(strap_raw))
        else $error("Latched strap changed outside reset");

    a_host_order: assert property (@(posedge clk_sys_i)
        reset_i |=> straps_o.host_code[0] == $past(pad_in_i[`RSCL_PIN_COEX_REQ])
            && straps_o.host_code[3] == $past(pad_in_i[`RSCL_PIN_COEX_FREQ]))
        else $error("Boot code bit order wrong");

    a_dbg_select: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ##1 debug_protocol_strap_o == rscl_dbg_e'($past(straps_o.dbg_sel)))
        else $error("Debug protocol does not follow strap");

    a_dbg_group: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ##1 (dbg_jtag_en_o != dbg_swd_en_o) && (dbg_jtag_en_o == $past(straps_o.dbg_sel)))
        else $error("Debug pin group not switched");

    a_osc_select: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        ##1 ref_osc_40m_o == $past(straps_o.osc_sel))
        else $error("Clock select does not follow strap");

    a_boot_flash: assert property (@(posedge clk_sys_i)
        straps_o.host_code == `RSCL_HOST_FLASH |=> boot_mode_o == RSCL_BOOT_FLASH)
        else $error("Code 1111 did not select flash boot");

    a_boot_sdio: assert property (@(posedge clk_sys_i)
        straps_o.host_code == `RSCL_HOST_SER_SDIO |=> boot_mode_o == RSCL_BOOT_SERIAL_SDIO)
        else $error("Code 1011 did not select SDIO serial boot");

    a_boot_prog: assert property (@(posedge clk_sys_i)
        straps_o.host_code == `RSCL_HOST_PROG |=> boot_mode_o == RSCL_BOOT_PROG)
        else $error("Code 1110 did not select programming boot");

    a_boot_serial: assert property (@(posedge clk_sys_i)
        straps_o.host_code == `RSCL_HOST_SERIAL |=> boot_mode_o == RSCL_BOOT_SERIAL)
        else $error("Code 1101 did not select serial boot");

    a_boot_prog_sdio: assert property (@(posedge clk_sys_i)
        straps_o.host_code == `RSCL_HOST_PROG_SDIO |=> boot_mode_o == RSCL_BOOT_PROG_SDIO)
        else $error("Code 1100 did not select SDIO programming boot");

    a_boot_reserved: assert property (@(posedge clk_sys_i)
        straps_o.host_code == `RSCL_HOST_RESERVED |=> boot_mode_o == RSCL_BOOT_RESERVED)
        else $error("Code 1010 not decoded as reserved");

endmodule : rscl_strap_latch

// ---- verilog/rscl_cfg.svh ----
`ifndef RSCL_CFG_SVH
`define RSCL_CFG_SVH

// Strap pin positions in the pad vector
`define RSCL_PIN_FE0         0
`define RSCL_PIN_FE1         1
`define RSCL_PIN_FE2         2
`define RSCL_PIN_FE3         3
`define RSCL_PIN_COEX_REQ    4
`define RSCL_PIN_COEX_GNT    5
`define RSCL_PIN_COEX_PRI    6
`define RSCL_PIN_COEX_FREQ   7
`define RSCL_NUM_PINS        8

// Pins whose normal function drives the pad
`define RSCL_FUNC_OUT_MASK   8'h2f

// Strap levels
`define RSCL_DBG_SWD         1'b0
`define RSCL_DBG_JTAG        1'b1
`define RSCL_OSC_38M4        1'b0
`define RSCL_OSC_40M         1'b1

// Boot source codes
`define RSCL_HOST_FLASH      4'hf
`define RSCL_HOST_PROG       4'he
`define RSCL_HOST_SERIAL     4'hd
`define RSCL_HOST_PROG_SDIO  4'hc
`define RSCL_HOST_SER_SDIO   4'hb
`define RSCL_HOST_RESERVED   4'ha

// Register map, byte offsets
`define RSCL_ADDR_W          8
`define RSCL_OFS_STRAP       8'h00
`define RSCL_OFS_BOOT        8'h04
`define RSCL_OFS_CTRL        8'h08

// Field positions
`define RSCL_BOOT_MODE_LSB   0
`define RSCL_BOOT_JTAG_BIT   4
`define RSCL_BOOT_OSC_BIT    5
`define RSCL_CTRL_OUTEN_BIT  0

// Reset values
`define RSCL_CTRL_RST        1'b1

`endif

// ---- verilog/rscl_pkg.sv ----
package rscl_pkg;

    typedef struct packed {
        logic [3:0] host_code;
        logic       osc_sel;
        logic       dbg_sel;
        logic       rsv1;
        logic       rsv0;
    } rscl_strap_s;

    typedef enum logic [2:0] {
        RSCL_BOOT_FLASH      = 3'b000,
        RSCL_BOOT_PROG       = 3'b001,
        RSCL_BOOT_SERIAL     = 3'b010,
        RSCL_BOOT_PROG_SDIO  = 3'b011,
        RSCL_BOOT_SERIAL_SDIO = 3'b100,
        RSCL_BOOT_RESERVED   = 3'b101,
        RSCL_BOOT_UNDEFINED  = 3'b110
    } rscl_boot_e;

    typedef enum logic {
        RSCL_DBG_SWD  = 1'b0,
        RSCL_DBG_JTAG = 1'b1
    } rscl_dbg_e;

endpackage : rscl_pkg

// ---- verilog/rscl_strap_cell.sv ----
`include "rscl_cfg.svh"

module rscl_strap_cell #(
    parameter bit FUNC_OUT = 1'b0
) (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    // Pad side
    input  wire logic pad_in_i,
    output logic      pad_out_o,
    output logic      pad_oe_o,
    // Core side
    input  wire logic func_out_i,
    input  wire logic func_oe_i,
    output logic      func_in_o,
    output logic      strap_o
);
    import rscl_pkg::*;

    // Pad level already includes the pull-up when floating
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            strap_o <= pad_in_i;
        end
    end

    // Input only under reset, function released at once after
    assign pad_oe_o  = !reset_i && FUNC_OUT && func_oe_i;
    assign pad_out_o = reset_i ? 1'b0 : func_out_i;
    assign func_in_o = reset_i ? 1'b1 : pad_in_i;

endmodule : rscl_strap_cell

// ---- tb/rscl_board_model.sv ----
`include "rscl_cfg.svh"

module rscl_board_model (
    // Pad side of the device
    input  wire logic [`RSCL_NUM_PINS-1:0] pad_out_i,
    input  wire logic [`RSCL_NUM_PINS-1:0] pad_oe_i,
    // Pads fitted with a resistor to ground
    input  wire logic [`RSCL_NUM_PINS-1:0] gnd_mask_i,
    output logic [`RSCL_NUM_PINS-1:0]      pad_level_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Undriven pads rest on the pull-up unless grounded; default mask leaves all floating
    assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ~gnd_mask_i);
endmodule : rscl_board_model

// ---- tb/reset_strap_config_latch_test.sv ----
module reset_strap_config_latch_test import rscl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [7:0]  gnd = 8'h00;
    logic [7:0]  pout, poe, plev;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, perr, err, req, pri, frq, o40, swd, jtg;
    logic [3:0]  fe = 4'h5;
    logic [3:0]  fe_oe = 4'hf;
    logic        gnt = 1'b1;
    rscl_strap_s st;
    rscl_boot_e  bm;
    rscl_dbg_e   dbg;
    int          n_errors = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #12.5 clk = ~clk;

    rscl_strap_latch uut (.clk_sys_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
        .pad_in_i(plev), .pad_out_o(pout), .pad_oe_o(poe), .front_end_ctrl_i(fe), .front_end_ctrl_oe_i(fe_oe),
        .coex_grant_out_i(gnt), .coex_request_in_o(req), .coex_priority_in_o(pri), .coex_frequency_in_o(frq),
        .straps_o(st), .boot_mode_o(bm), .debug_protocol_strap_o(dbg), .ref_osc_40m_o(o40),
        .dbg_swd_en_o(swd), .dbg_jtag_en_o(jtg));

    rscl_board_model board (.pad_out_i(pout), .pad_oe_i(poe), .gnd_mask_i(gnd), .pad_level_o(plev));

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task finish_test;
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            finish_test();
        end
    end

    function automatic rscl_boot_e mode_of(input logic [3:0] c);
        case (c)
            4'hf: return RSCL_BOOT_FLASH;
            4'he: return RSCL_BOOT_PROG;
            4'hd: return RSCL_BOOT_SERIAL;
            4'hc: return RSCL_BOOT_PROG_SDIO;
            4'hb: return RSCL_BOOT_SERIAL_SDIO;
            4'ha: return RSCL_BOOT_RESERVED;
            default: return RSCL_BOOT_UNDEFINED;
        endcase
    endfunction : mode_of

    // Request held until pready is seen at an edge; wait-state count checked to be zero
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            k++;
            @(posedge clk);
        end
        chk("wait_states", 0, k);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    task rst_to(input logic [7:0] g);
        @(posedge clk);
        gnd <= g;
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        chk("oe_in_reset", 0, poe);
        rst <= 1'b0;
        #1;
        chk("oe_after_reset", 8'h2f, poe);
        repeat (2) @(posedge clk);
    endtask : rst_to

    task t_codes;
        logic [3:0] codes [8];
        logic [7:0] g, e;
        codes = '{4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h0, 4'h9};
        for (int i = 0; i < 8; i++) begin
            g = {~codes[i], i[0] ? 4'b1100 : 4'b0000};
            e = ~g;
            rst_to(g);
            chk("straps", {24'h0, e}, st);
            chk("boot_mode", mode_of(codes[i]), bm);
            chk("dbg_sel", e[2], dbg);
            chk("jtag_en", e[2], jtg);
            chk("swd_en", !e[2], swd);
            chk("osc_40m", e[3], o40);
            apb(0, 8'h04, 0);
            chk("boot_reg", {26'h0, e[3], e[2], 1'b0, mode_of(codes[i])}, rd);
            chk("boot_err", 0, err);
            apb(0, 8'h00, 0);
            chk("strap_reg", {24'h0, e}, rd);
        end
        $display("Test codes done");
    endtask : t_codes

    // Pads change once running; latched configuration must not follow
    task t_hold;
        rst_to(8'h30);
        gnd <= 8'h50;
        fe <= 4'ha;
        repeat (2) @(posedge clk);
        chk("straps_held", 8'hcf, st);
        chk("mode_held", RSCL_BOOT_PROG_SDIO, bm);
        chk("fe_out", 4'ha, pout[3:0]);
        chk("grant_out", gnt, pout[5]);
        chk("req_in", 0, req);
        chk("pri_in", 0, pri);
        chk("freq_in", 1, frq);
        gnd <= 8'h00;
        $display("Test hold done");
    endtask : t_hold

    task t_regs;
        rst_to(8'h00);
        apb(0, 8'h08, 0);
        chk("ctrl_reset", 1, rd);
        apb(1, 8'h00, 0);
        apb(0, 8'h00, 0);
        chk("strap_ro", 32'hff, rd);
        apb(1, 8'h08, 0);
        #1;
        chk("oe_disabled", 0, poe);
        apb(0, 8'h08, 0);
        chk("ctrl_rw", 0, rd);
        apb(1, 8'h08, 1);
        apb(0, 8'h0c, 0);
        chk("unmapped_err", 1, err);
        chk("unmapped_rd", 0, rd);
        apb(1, 8'h0c, 1);
        chk("unmapped_werr", 1, err);
        apb(0, 8'h04, 0);
        chk("boot_default", 32'h30, rd);
        $display("Test regs done");
    endtask : t_regs

    initial begin
        t_codes();
        t_hold();
        t_regs();
        finish_test();
    end
endmodule : reset_strap_config_latch_test
